// ===== hdl/emulator_memory_map_protect.sv
`default_nettype none
module emulator_memory_map_protect #(
    parameter int STALL_CYC = mmap_pkg::EE_STALL_CYC
) (
    input  wire logic                 core_clk,
    input  wire logic                 rstn,
    input  wire mmap_pkg::cpu_cyc_t   cpu,
    input  wire logic                 cpu_resume,
    input  wire logic                 cfg_we,
    input  wire logic [11:0]          cfg_frame,
    input  wire mmap_pkg::map_entry_t cfg_entry,
    output mmap_pkg::src_t            mem_src,
    output logic                      cpu_halt,
    output logic                      trap,
    output logic                      ee_busy,
    output logic [7:0]                emu_rdata
);
    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_periph(input logic [15:0] a);
        return (a >= mmap_pkg::PERIPH_BASE) && (a <= mmap_pkg::PERIPH_END);
    endfunction

    // Peripheral frames may only go inside or to the expansion board.
    function automatic mmap_pkg::src_t legal_src(input logic [15:0] a,
                                                 input mmap_pkg::src_t s);
        if (is_periph(a) && s != mmap_pkg::SRC_EXPANSION) begin
            return mmap_pkg::SRC_INTERNAL;
        end
        return s;
    endfunction

    // ----------------------------------------------------------------
    // Frame table and emulator RAM
    // ----------------------------------------------------------------
    mmap_pkg::map_entry_t map_tab [4096];
    logic [7:0]           emu_ram [mmap_pkg::EMU_BYTES];

    logic [11:0]          frame;
    mmap_pkg::map_entry_t entry;
    logic [15:0]          cfg_addr;
    mmap_pkg::map_entry_t cfg_fixed;

    assign frame    = cpu.addr[15:mmap_pkg::FRAME_LSB];
    assign entry    = map_tab[frame];
    assign cfg_addr = {cfg_frame, 4'h0};

    always_comb begin
        cfg_fixed     = cfg_entry;
        cfg_fixed.src = legal_src(cfg_addr, cfg_entry.src);
    end

    // A full async reset of the table is what makes every frame start
    // out fully protected; the cost is a large reset tree.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 4096; i++) begin
                map_tab[i] <= mmap_pkg::MAP_RESET;
            end
        end else if (cfg_we) begin
            map_tab[cfg_frame] <= cfg_fixed;
        end
    end

    // ----------------------------------------------------------------
    // Access decode and protection
    // ----------------------------------------------------------------
    logic prot_halt;
    logic next_prot_halt;
    logic next_trap;
    logic in_regfile;
    logic in_ee;
    logic is_ctrl;
    logic live;
    logic viol;
    logic ram_we;
    logic [15:0] ram_waddr;
    logic [7:0]  ram_wdata;
    logic [7:0]  next_rdata;

    assign in_regfile = cpu.addr <= mmap_pkg::REGFILE_END;
    assign in_ee      = (cpu.addr >= mmap_pkg::EE_BASE) &&
                        (cpu.addr <= mmap_pkg::EE_END);
    assign is_ctrl    = cpu.addr == mmap_pkg::EE_CTRL;
    assign live       = cpu.valid && !cpu_halt;

    always_comb begin
        if (in_regfile) begin
            mem_src = mmap_pkg::SRC_INTERNAL;
        end else begin
            mem_src = legal_src(cpu.addr, entry.src);
        end
    end

    // The register file is never checked, so the default protection
    // cannot lock the CPU out of its own registers.
    assign viol = live && !in_regfile &&
                  (cpu.write ? entry.wr_prot : entry.rd_prot);

    // ----------------------------------------------------------------
    // EEPROM imitation
    // ----------------------------------------------------------------
    mmap_pkg::ee_state_t ee_state;
    mmap_pkg::ee_state_t next_ee_state;
    logic [31:0] ee_cnt;
    logic [31:0] next_ee_cnt;
    logic [1:0]  ee_op;
    logic [1:0]  next_ee_op;
    logic [15:0] ee_addr;
    logic [15:0] next_ee_addr;
    logic [7:0]  ee_data;
    logic [7:0]  next_ee_data;
    logic        ee_start;
    logic        ee_done;

    assign ee_start = live && cpu.write && in_ee && !viol &&
                      (ee_op != 2'h0);
    assign ee_done  = (ee_state == mmap_pkg::EE_STALL) &&
                      (ee_cnt == 32'h0000_0001);

    always_comb begin
        next_ee_state = ee_state;
        next_ee_cnt   = ee_cnt;
        next_ee_op    = ee_op;
        next_ee_addr  = ee_addr;
        next_ee_data  = ee_data;
        if (live && cpu.write && is_ctrl) begin
            next_ee_op = {cpu.wdata[mmap_pkg::EE_ERASE_BIT],
                          cpu.wdata[mmap_pkg::EE_PROG_BIT]};
        end
        case (ee_state)
            mmap_pkg::EE_IDLE: begin
                if (ee_start) begin
                    next_ee_state = mmap_pkg::EE_STALL;
                    next_ee_cnt   = 32'(STALL_CYC);
                    next_ee_addr  = cpu.addr;
                    next_ee_data  = cpu.wdata;
                end
            end
            mmap_pkg::EE_STALL: begin
                next_ee_cnt = ee_cnt - 32'h0000_0001;
                if (ee_done) begin
                    next_ee_state = mmap_pkg::EE_IDLE;
                end
            end
            default: begin
                next_ee_state = mmap_pkg::EE_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ee_state <= mmap_pkg::EE_IDLE;
            ee_cnt   <= 32'h0000_0000;
            ee_op    <= 2'h0;
            ee_addr  <= 16'h0000;
            ee_data  <= 8'h00;
        end else begin
            ee_state <= next_ee_state;
            ee_cnt   <= next_ee_cnt;
            ee_op    <= next_ee_op;
            ee_addr  <= next_ee_addr;
            ee_data  <= next_ee_data;
        end
    end

    assign ee_busy = ee_state == mmap_pkg::EE_STALL;

    // ----------------------------------------------------------------
    // RAM port, halt and trap
    // ----------------------------------------------------------------
    always_comb begin
        ram_we    = 1'b0;
        ram_waddr = cpu.addr;
        ram_wdata = cpu.wdata;
        if (ee_done) begin
            ram_we    = 1'b1;
            ram_waddr = ee_addr;
            // Erase wins over program; no exact cell model is kept.
            ram_wdata = ee_op[1] ? mmap_pkg::EE_ERASED : ee_data;
        end else if (live && cpu.write && !viol && !in_ee &&
                     mem_src == mmap_pkg::SRC_EMU) begin
            ram_we = 1'b1;
        end
        next_rdata = emu_rdata;
        if (live && !cpu.write && !viol && mem_src == mmap_pkg::SRC_EMU) begin
            next_rdata = emu_ram[cpu.addr];
        end
        // A new violation wins over a resume in the same cycle.
        next_prot_halt = viol || (prot_halt && !cpu_resume);
        next_trap      = viol || ee_start;
    end

    always_ff @(posedge core_clk) begin
        if (ram_we) begin
            emu_ram[ram_waddr] <= ram_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prot_halt <= 1'b0;
            trap      <= 1'b0;
            emu_rdata <= 8'h00;
        end else begin
            prot_halt <= next_prot_halt;
            trap      <= next_trap;
            emu_rdata <= next_rdata;
        end
    end

    assign cpu_halt = prot_halt || ee_busy;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_regfile_inside: assert property (@(posedge core_clk) disable iff (!rstn)
        cpu.valid && in_regfile |-> mem_src == mmap_pkg::SRC_INTERNAL)
        else $error("register file access not routed inside");

    a_periph_src_legal: assert property (@(posedge core_clk) disable iff (!rstn)
        cpu.valid && is_periph(cpu.addr) |->
        mem_src inside {mmap_pkg::SRC_INTERNAL, mmap_pkg::SRC_EXPANSION})
        else $error("peripheral frame routed to illegal source");

    a_viol_halts: assert property (@(posedge core_clk) disable iff (!rstn)
        viol |=> trap && cpu_halt)
        else $error("protected cycle did not trap and halt");

    a_halt_holds: assert property (@(posedge core_clk) disable iff (!rstn)
        prot_halt && !cpu_resume |=> cpu_halt)
        else $error("halt released without resume");

    a_prot_blocks_wr: assert property (@(posedge core_clk) disable iff (!rstn)
        live && cpu.write && !in_regfile && entry.wr_prot && !ee_done
        |-> !ram_we)
        else $error("write to protected frame reached RAM");

    a_rd_prot_check: assert property (@(posedge core_clk) disable iff (!rstn)
        live && !cpu.write && !in_regfile && entry.rd_prot |=> trap)
        else $error("read of read-protected frame not trapped");

    a_ee_stall_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        ee_start |=> ee_busy [*8])
        else $error("EEPROM stall ended too early");

    a_ee_release: assert property (@(posedge core_clk) disable iff (!rstn)
        ee_done |-> ram_we ##1 !ee_busy)
        else $error("EEPROM imitation did not finish cleanly");
endmodule
`default_nettype wire

// ===== hdl/mmap_pkg.sv
// Operation
// - Address space split into 16-byte frames.
// - Each frame routes to one chosen source.
// - Provide 64K bytes of emulator RAM.
// - Register file range always served internally.
// - Peripheral frames: internal or expansion only.
// - Frame protection checked against cycle type.
// - Protected cycle traps and halts the CPU.
// - Unmapped frames default to full protection.
// - ROM is write-protected emulator RAM.
// - Trap EEPROM writes, imitate in RAM; code traps only with program or erase armed in EE_CTRL, others are dropped.
// - EEPROM trap stalls CPU about 12 ms.
`default_nettype none
package mmap_pkg;
    localparam int ADDR_W    = 16;
    localparam int DATA_W    = 8;
    localparam int FRAME_LSB = 4;
    localparam int FRAME_W   = 12;
    localparam int EMU_BYTES = 65536;

    localparam logic [15:0] REGFILE_END = 16'h00FF;
    localparam logic [15:0] PERIPH_BASE = 16'h1000;
    localparam logic [15:0] PERIPH_END  = 16'h10FF;
    localparam logic [15:0] EE_CTRL     = 16'h1010;
    localparam logic [15:0] EE_BASE     = 16'h1F00;
    localparam logic [15:0] EE_END      = 16'h1FFF;

    localparam int EE_PROG_BIT  = 0;
    localparam int EE_ERASE_BIT = 1;
    localparam logic [7:0] EE_ERASED = 8'h00;

    localparam int EE_STALL_MS  = 12;
    localparam int CLK_KHZ      = 250000;
    localparam int EE_STALL_CYC = EE_STALL_MS * CLK_KHZ;

    typedef enum logic [1:0] {
        SRC_INTERNAL,
        SRC_TARGET,
        SRC_EMU,
        SRC_EXPANSION
    } src_t;

    typedef struct packed {
        src_t src;
        logic rd_prot;
        logic wr_prot;
    } map_entry_t;

    localparam map_entry_t MAP_RESET = '{SRC_TARGET, 1'b1, 1'b1};

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cpu_cyc_t;

    typedef enum logic {EE_IDLE, EE_STALL} ee_state_t;
endpackage
`default_nettype wire

// ===== tb/cpu_model.sv
`default_nettype none
module cpu_model (
    input  wire logic           core_clk,
    input  wire logic           cpu_halt,
    input  wire mmap_pkg::src_t mem_src,
    output mmap_pkg::cpu_cyc_t  cpu
);
    timeunit 1ns;
    timeprecision 1ps;
    mmap_pkg::src_t seen_src;
    initial cpu = '0;
    // One byte access per cycle; a halted CPU issues nothing new until the halt drops or it has waited 100 cycles.
    // Released fields show the inverse of the last value, so a design
    // that samples outside the cycle sees garbage.
    task automatic access(input logic wr, input logic [15:0] a,
                          input logic [7:0] d, output logic ok);
        int n;
        n = 0;
        ok = 1'b1;
        @(negedge core_clk);
        while (cpu_halt !== 1'b0 && n < 100) begin
            n++;
            @(negedge core_clk);
        end
        if (n == 100) ok = 1'b0;
        cpu = '{1'b1, wr, a, d};
        // The routing is combinational, so it is read once it has settled
        // and before the edge that takes the cycle.
        #1ns seen_src = mem_src;
        @(posedge core_clk);
        @(negedge core_clk);
        cpu = '{1'b0, ~wr, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STALL = 10;
    logic                 core_clk;
    logic                 rstn;
    logic                 cpu_resume;
    logic                 cfg_we;
    logic [11:0]          cfg_frame;
    mmap_pkg::map_entry_t cfg_entry;
    mmap_pkg::cpu_cyc_t   cpu;
    mmap_pkg::src_t       mem_src;
    logic                 cpu_halt;
    logic                 trap;
    logic                 ee_busy;
    logic [7:0]           emu_rdata;
    logic                 ok;
    int                   errors;
    int                   checked;

    emulator_memory_map_protect #(.STALL_CYC(STALL))
        emulator_memory_map_protect_i (
        .core_clk(core_clk), .rstn(rstn), .cpu(cpu),
        .cpu_resume(cpu_resume), .cfg_we(cfg_we), .cfg_frame(cfg_frame),
        .cfg_entry(cfg_entry), .mem_src(mem_src), .cpu_halt(cpu_halt),
        .trap(trap), .ee_busy(ee_busy), .emu_rdata(emu_rdata));
    cpu_model cpu_model_i (
        .core_clk(core_clk), .cpu_halt(cpu_halt), .mem_src(mem_src),
        .cpu(cpu));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    task automatic end_sim();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cfg(input logic [11:0] f, input mmap_pkg::src_t s,
                       input logic rp, input logic wp);
        @(negedge core_clk);
        cfg_we = 1'b1;
        cfg_frame = f;
        cfg_entry = '{s, rp, wp};
        @(negedge core_clk);
        cfg_we = 1'b0;
    endtask

    // Issues one access, watches three cycles for a trap, then resumes.
    task automatic run(input logic wr, input logic [15:0] a,
                       input logic [7:0] d, input logic exp_trap);
        logic t;
        cpu_model_i.access(wr, a, d, ok);
        if (!ok) begin
            errors++;
            end_sim();
        end
        t = trap;
        repeat (2) begin
            @(negedge core_clk);
            t = t | trap;
        end
        check(t, exp_trap);
        check(cpu_halt, exp_trap);
        cpu_resume = 1'b1;
        @(negedge core_clk);
        cpu_resume = 1'b0;
        @(negedge core_clk);
        check(cpu_halt, 1'b0);
    endtask

    task automatic ee_op(input logic [7:0] op, input logic [7:0] d,
                         input logic [7:0] exp);
        int n;
        logic t;
        n = 0;
        t = 1'b0;
        run(1'b1, 16'h1010, op, 1'b0);
        cpu_model_i.access(1'b1, 16'h1F05, d, ok);
        if (!ok) begin
            errors++;
            end_sim();
        end
        for (int i = 0; i < STALL + 10; i++) begin
            t = t | trap;
            if (ee_busy === 1'b1) n++;
            @(negedge core_clk);
        end
        check(t, 1'b1);
        check(n, STALL);
        run(1'b0, 16'h1F05, 8'h00, 1'b0);
        check(emu_rdata, exp);
        $display("test eeprom op %h done", op);
    endtask

    // With no operation armed an EEPROM write must neither trap nor land.
    task automatic ee_refused();
        run(1'b1, 16'h1010, 8'h00, 1'b0);
        run(1'b1, 16'h1F05, 8'h99, 1'b0);
        run(1'b0, 16'h1F05, 8'h00, 1'b0);
        check(emu_rdata, 8'h00);
        check(ee_busy, 1'b0);
        $display("test eeprom refused done");
    endtask

    task automatic test_map();
        run(1'b0, 16'h2000, 8'h00, 1'b1);
        check(cpu_model_i.seen_src, mmap_pkg::SRC_TARGET);
        run(1'b1, 16'h0050, 8'h11, 1'b0);
        check(cpu_model_i.seen_src, mmap_pkg::SRC_INTERNAL);
        cfg(12'h200, mmap_pkg::SRC_EMU, 1'b0, 1'b0);
        run(1'b1, 16'h200F, 8'hA5, 1'b0);
        run(1'b0, 16'h200F, 8'h00, 1'b0);
        check(emu_rdata, 8'hA5);
        check(cpu_model_i.seen_src, mmap_pkg::SRC_EMU);
        run(1'b0, 16'h2010, 8'h00, 1'b1);
        cfg(12'h100, mmap_pkg::SRC_TARGET, 1'b0, 1'b0);
        run(1'b0, 16'h1008, 8'h00, 1'b0);
        check(cpu_model_i.seen_src, mmap_pkg::SRC_INTERNAL);
        cfg(12'h100, mmap_pkg::SRC_EXPANSION, 1'b0, 1'b0);
        run(1'b0, 16'h1008, 8'h00, 1'b0);
        check(cpu_model_i.seen_src, mmap_pkg::SRC_EXPANSION);
        $display("test mapping done");
    endtask

    // Walks all four protection settings; a blocked write keeps old data.
    task automatic test_prot();
        logic [7:0] stored;
        logic [1:0] m;
        cfg(12'h300, mmap_pkg::SRC_EMU, 1'b0, 1'b0);
        run(1'b1, 16'h3004, 8'h3C, 1'b0);
        stored = 8'h3C;
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            cfg(12'h300, mmap_pkg::SRC_EMU, m[1], m[0]);
            run(1'b1, 16'h3004, 8'h40 + 8'(i), m[0]);
            if (!m[0]) stored = 8'h40 + 8'(i);
            run(1'b0, 16'h3004, 8'h00, m[1]);
            cfg(12'h300, mmap_pkg::SRC_EMU, 1'b0, 1'b0);
            run(1'b0, 16'h3004, 8'h00, 1'b0);
            check(emu_rdata, stored);
        end
        $display("test protection done");
    endtask

    initial begin
        errors = 0;
        checked = 0;
        rstn = 1'b0;
        cpu_resume = 1'b0;
        cfg_we = 1'b0;
        cfg_frame = 12'h000;
        cfg_entry = '0;
        repeat (20) @(negedge core_clk);
        rstn = 1'b1;
        test_map();
        test_prot();
        cfg(12'h101, mmap_pkg::SRC_INTERNAL, 1'b0, 1'b0);
        cfg(12'h1F0, mmap_pkg::SRC_EMU, 1'b0, 1'b0);
        ee_op(8'h01, 8'h5A, 8'h5A);
        ee_op(8'h02, 8'h77, 8'h00);
        ee_op(8'h01, 8'h5A, 8'h5A);
        ee_op(8'h03, 8'h33, 8'h00);
        ee_refused();
        end_sim();
    end
endmodule
`default_nettype wire
